// file: pcoc_clock_output_ctrl.sv
// pll control and auxiliary clock pin selection with its two registers
// assumes crystal, pll stage and timer events arrive as mclk-synchronous one-cycle pulses
// assumes the analog loop sits outside and reads pll_power_down and pll_feedback_mult
`include "pcoc_regs.svh"

module pcoc_clock_output_ctrl (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // register port
    input  wire logic [`PCOC_ADDR_W-1:0] reg_addr,
    input  wire pcoc_pkg::pcoc_byte_t    reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output pcoc_pkg::pcoc_byte_t         reg_rdata,
    // event sources
    input  wire logic                    xtal_edge_tick,
    input  wire logic                    pll_stage_edge_tick,
    input  wire logic [3:0]              timer_overflow,
    // analog pll controls
    output logic                         pll_power_down,
    output logic [4:0]                   pll_feedback_mult,
    // gpio use of the pin
    input  wire logic                    gpio_out,
    input  wire logic                    gpio_drive,
    output logic                         gpio_in_level,
    // auxiliary clock pin
    input  wire logic                    aux_clock_pin_in,
    output logic                         aux_clock_pin_out,
    output logic                         aux_clock_pin_oe_n
);
    import pcoc_pkg::*;

    pcoc_byte_t pll_control;
    pcoc_byte_t pll_output_ratio;
    pcoc_byte_t next_pll_control;
    pcoc_byte_t next_pll_output_ratio;
    pcoc_byte_t next_reg_rdata;

    logic [2:0] xtal_count;
    logic [2:0] next_xtal_count;
    logic       timer_level;
    logic       next_timer_level;
    logic       pll_level;
    logic       next_aux_out;
    logic       next_aux_oe_n;
    logic [2:0] pin_sync;
    logic       next_gpio_in_level;

    logic       xtal_div8;
    logic       next_xtal_div8;

    logic [3:0] aux_clock_source_select;
    logic       aux_clock_pin_enable;
    logic [1:0] pll_feedback_ratio;
    logic       pll_run;

    assign aux_clock_source_select = pll_control[`PCOC_SEL_HI:`PCOC_SEL_LO];
    assign aux_clock_pin_enable    = pll_control[`PCOC_EN_BIT];
    assign pll_feedback_ratio      = pll_control[`PCOC_FB_HI:`PCOC_FB_LO];

    function automatic logic [4:0] fb_mult(input logic [1:0] code);
        case (code)
            2'b01:   fb_mult = `PCOC_FB_MULT_B;
            2'b10:   fb_mult = `PCOC_FB_MULT_C;
            default: fb_mult = `PCOC_FB_MULT_A;
        endcase
    endfunction

    // register file
    // unmapped addresses swallow writes and read back as zero
    always_comb begin
        next_pll_control      = pll_control;
        next_pll_output_ratio = pll_output_ratio;
        next_reg_rdata        = 8'h00;
        if (reg_write) begin
            if (reg_addr == `PCOC_PLL_CONTROL_OFS) begin
                next_pll_control = reg_wdata;
            end
            // ratio store
            // reserved ratios are stored as written; pll_run keeps them from dividing
            if (reg_addr == `PCOC_PLL_OUT_DIV_OFS) begin
                next_pll_output_ratio = reg_wdata;
            end
        end
        if (reg_read) begin
            case (reg_addr)
                `PCOC_PLL_CONTROL_OFS: next_reg_rdata = pll_control;
                `PCOC_PLL_OUT_DIV_OFS: next_reg_rdata = pll_output_ratio;
                default:               next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pll_control      <= `PCOC_PLL_CONTROL_RST;
            pll_output_ratio <= `PCOC_PLL_OUT_DIV_RST;
            reg_rdata        <= 8'h00;
        end else begin
            pll_control      <= next_pll_control;
            pll_output_ratio <= next_pll_output_ratio;
            reg_rdata        <= next_reg_rdata;
        end
    end

    assign pll_power_down    = pll_control[`PCOC_PD_BIT];
    assign pll_feedback_mult = fb_mult(pll_feedback_ratio);
    // ratio range guard
    // reserved ratios below eight are not divided, the stage stays quiet
    assign pll_run = !pll_power_down && (pll_output_ratio >= `PCOC_OUT_DIV_MIN);

    // first-stage edges of the analog loop arrive here as ticks
    // second stage divide
    pcoc_ratio_divider u_out_div (
        .mclk      (mclk),
        .reset     (reset),
        .run       (pll_run),
        .ratio     (pll_output_ratio),
        .edge_tick (pll_stage_edge_tick),
        .div_level (pll_level)
    );

    // crystal dividers, timer toggle and pin mux
    always_comb begin
        next_xtal_count  = xtal_count;
        next_xtal_div8   = xtal_div8;
        next_timer_level = timer_level;
        next_aux_out     = 1'b0;
        next_aux_oe_n    = 1'b0;
        if (xtal_edge_tick) begin
            next_xtal_count = xtal_count + 3'h1;
            // divide by eight needs one toggle stage past the 3-bit counter
            if (xtal_count == 3'h7) begin
                next_xtal_div8 = ~xtal_div8;
            end
        end
        // timer overflow toggle
        // the level is kept across selector changes, so a reselected timer resumes from it
        if (aux_clock_source_select[3:2] == 2'b10 &&
            timer_overflow[aux_clock_source_select[1:0]]) begin
            next_timer_level = ~timer_level;
        end
        case (aux_clock_source_select)
            PCOC_SEL_GPIO: begin
                next_aux_out  = gpio_out;
                next_aux_oe_n = ~gpio_drive;
            end
            PCOC_SEL_PLL:   next_aux_out = pll_level & aux_clock_pin_enable;
            PCOC_SEL_LOW:   next_aux_out = 1'b0;
            PCOC_SEL_HIGH:  next_aux_out = 1'b1;
            PCOC_SEL_XTAL1: next_aux_out = xtal_count[0] & aux_clock_pin_enable;
            PCOC_SEL_XTAL2: next_aux_out = xtal_count[1] & aux_clock_pin_enable;
            PCOC_SEL_XTAL4: next_aux_out = xtal_count[2] & aux_clock_pin_enable;
            PCOC_SEL_XTAL8: next_aux_out = xtal_div8 & aux_clock_pin_enable;
            PCOC_SEL_TMR0, PCOC_SEL_TMR1, PCOC_SEL_TMR2, PCOC_SEL_TMR3: begin
                next_aux_out = timer_level & aux_clock_pin_enable;
            end
            default:        next_aux_out = 1'b0;
        endcase
    end

    // every pin source leaves through one flop, so mux glitches never reach the pin
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xtal_count         <= 3'h0;
            xtal_div8          <= 1'b0;
            timer_level        <= 1'b0;
            aux_clock_pin_out  <= 1'b0;
            aux_clock_pin_oe_n <= 1'b1;
        end else begin
            xtal_count         <= next_xtal_count;
            xtal_div8          <= next_xtal_div8;
            timer_level        <= next_timer_level;
            aux_clock_pin_out  <= next_aux_out;
            aux_clock_pin_oe_n <= next_aux_oe_n;
        end
    end

    // pin input: three stages, a change counts once the last two agree
    // the first stage may go metastable, so only stages two and three are compared;
    // this costs two cycles of latency against a plain two-flop synchroniser
    always_comb begin
        next_gpio_in_level = gpio_in_level;
        if (pin_sync[1] == pin_sync[2]) begin
            next_gpio_in_level = pin_sync[2];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_sync      <= 3'h0;
            gpio_in_level <= 1'b0;
        end else begin
            pin_sync      <= {pin_sync[1:0], aux_clock_pin_in};
            gpio_in_level <= next_gpio_in_level;
        end
    end
endmodule

// file: pcoc_out_checker.sv
// assertions for the pll clock output block
// assumes it is bound to the top module and sees only its ports
`include "pcoc_regs.svh"
module pcoc_out_checker (
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    reset,
    // register port
    input wire logic [`PCOC_ADDR_W-1:0] reg_addr,
    input wire pcoc_pkg::pcoc_byte_t    reg_wdata,
    input wire logic                    reg_write,
    input wire logic                    reg_read,
    input wire pcoc_pkg::pcoc_byte_t    reg_rdata,
    // events and outputs
    input wire logic [3:0]              timer_overflow,
    input wire logic                    pll_power_down,
    input wire logic [4:0]              pll_feedback_mult,
    input wire logic                    gpio_out,
    input wire logic                    gpio_drive,
    input wire logic                    aux_clock_pin_out,
    input wire logic                    aux_clock_pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import pcoc_pkg::*;
    pcoc_byte_t ctl;
    pcoc_byte_t next_ctl;
    logic [3:0] sel;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // shadow of the control register, rebuilt from the write strobes
    always_comb next_ctl = (reg_write && reg_addr == `PCOC_PLL_CONTROL_OFS) ? reg_wdata : ctl;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) ctl <= `PCOC_PLL_CONTROL_RST;
        else ctl <= next_ctl;
    end
    assign sel = ctl[7:4];
    pd_follow_a: assert property (pll_power_down == ctl[2])
        else $error("power down output differs from control");
    fb_decode_a: assert property (pll_feedback_mult == ((ctl[1:0] == 2'h1) ? 5'h1b :
        (ctl[1:0] == 2'h2) ? 5'h1c : 5'h17)) else $error("feedback multiplier wrong");
    hold_low_a: assert property ($past(sel) == 4'h2 |-> !aux_clock_pin_out && !aux_clock_pin_oe_n)
        else $error("pin not held low");
    hold_high_a: assert property ($past(sel) == 4'h3 |-> aux_clock_pin_out && !aux_clock_pin_oe_n)
        else $error("pin not held high");
    rsvd_low_a: assert property ($past(sel) >= 4'hc |-> !aux_clock_pin_out)
        else $error("reserved code moved the pin");
    gate_off_a: assert property (!$past(ctl[3]) && $past(sel) inside {4'h1, [4'h4:4'hb]}
        |-> !aux_clock_pin_out) else $error("clock seen while disabled");
    gpio_pass_a: assert property (!$past(reset) && $past(sel) == 4'h0
        |-> aux_clock_pin_oe_n == !$past(gpio_drive) && aux_clock_pin_out == $past(gpio_out))
        else $error("gpio use of pin wrong");
    tmr_toggle_a: assert property ((sel == 4'h8 && ctl[3] && $stable(ctl) && timer_overflow[0])
        ##1 (!timer_overflow[0] && $stable(ctl)) |=> $changed(aux_clock_pin_out))
        else $error("timer overflow did not toggle pin");
    rd_ctl_a: assert property (reg_read && reg_addr == `PCOC_PLL_CONTROL_OFS
        |=> reg_rdata == $past(ctl)) else $error("control readback wrong");
    rd_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    cover property (sel == 4'h1 && ctl[3]);
    cover property (sel == 4'h8 && ctl[3] && timer_overflow[0]);
    cover property ($past(sel) == 4'h3);
endmodule

// file: pcoc_pkg.sv
// types shared by the pll clock output block
// assumes nothing beyond the register header
package pcoc_pkg;
    typedef enum logic [3:0] {
        PCOC_SEL_GPIO   = 4'h0,
        PCOC_SEL_PLL    = 4'h1,
        PCOC_SEL_LOW    = 4'h2,
        PCOC_SEL_HIGH   = 4'h3,
        PCOC_SEL_XTAL1  = 4'h4,
        PCOC_SEL_XTAL2  = 4'h5,
        PCOC_SEL_XTAL4  = 4'h6,
        PCOC_SEL_XTAL8  = 4'h7,
        PCOC_SEL_TMR0   = 4'h8,
        PCOC_SEL_TMR1   = 4'h9,
        PCOC_SEL_TMR2   = 4'ha,
        PCOC_SEL_TMR3   = 4'hb
    } pcoc_sel_t;

    typedef logic [7:0] pcoc_byte_t;
endpackage

// file: pcoc_ratio_divider.sv
// edge-count divider: output toggles after every ratio input edges
// assumes edge_tick is a one-cycle pulse on mclk, one per input edge
`include "pcoc_regs.svh"

module pcoc_ratio_divider (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset,
    // control
    input  wire logic                 run,
    input  wire pcoc_pkg::pcoc_byte_t ratio,
    input  wire logic                 edge_tick,
    // divided level
    output logic                      div_level
);
    import pcoc_pkg::*;

    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_div_level;

    always_comb begin
        next_count     = count;
        next_div_level = div_level;
        if (!run) begin
            // stopped: hold low so no edge leaks out
            next_count     = 8'h00;
            next_div_level = 1'b0;
        end else if (edge_tick) begin
            if (count >= ratio - 8'h01) begin
                next_count     = 8'h00;
                next_div_level = ~div_level;
            end else begin
                next_count = count + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count     <= 8'h00;
            div_level <= 1'b0;
        end else begin
            count     <= next_count;
            div_level <= next_div_level;
        end
    end
endmodule

// file: pcoc_regs.svh
// register offsets, field positions, reset values and feedback multipliers for the pll clock output block
// assumes byte-wide registers reached over a plain address/strobe port
`ifndef PCOC_REGS_SVH
`define PCOC_REGS_SVH

`define PCOC_ADDR_W            8
`define PCOC_PLL_CONTROL_OFS   8'h3d
`define PCOC_PLL_OUT_DIV_OFS   8'h3e

`define PCOC_SEL_HI            7
`define PCOC_SEL_LO            4
`define PCOC_EN_BIT            3
`define PCOC_PD_BIT            2
`define PCOC_FB_HI             1
`define PCOC_FB_LO             0

`define PCOC_PLL_CONTROL_RST   8'h00
`define PCOC_PLL_OUT_DIV_RST   8'h08
`define PCOC_OUT_DIV_MIN       8'h08

`define PCOC_FB_MULT_A         5'h17
`define PCOC_FB_MULT_B         5'h1b
`define PCOC_FB_MULT_C         5'h1c

`endif

// file: tb_top.sv
// self-checking bench for the pll clock output block
// assumes the design's header and package are compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pcoc_pkg::*;
    logic       mclk, reset, reg_write, reg_read, xtal_tick, stage_tick;
    logic       gpio_out, gpio_drive, ext_level, pin_out, pin_oe_n, pin_wire;
    logic       pll_power_down, gpio_in_level;
    logic [7:0] reg_addr;
    logic [3:0] timer_overflow;
    logic [4:0] pll_feedback_mult;
    pcoc_byte_t reg_wdata, reg_rdata, rd_val;
    int         n_errors, n_tests, tog;
    // wire level of the two-way pin: the bench drives only when the design lets go
    assign pin_wire = pin_oe_n ? ext_level : pin_out;
    pcoc_clock_output_ctrl uut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .xtal_edge_tick(xtal_tick), .pll_stage_edge_tick(stage_tick),
        .timer_overflow(timer_overflow), .pll_power_down(pll_power_down),
        .pll_feedback_mult(pll_feedback_mult), .gpio_out(gpio_out), .gpio_drive(gpio_drive),
        .gpio_in_level(gpio_in_level), .aux_clock_pin_in(pin_wire),
        .aux_clock_pin_out(pin_out), .aux_clock_pin_oe_n(pin_oe_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    // pulse masked events n times, two cycles apart, and count pin transitions
    task automatic ticks(input logic [5:0] m, input int n);
        logic last;
        logic p;
        tog = 0;
        repeat (4) @(posedge mclk);
        #1 last = pin_out;
        for (int i = 0; i < 2 * n + 4; i++) begin
            p = i < 2 * n && i % 2 == 0;
            @(posedge mclk);
            xtal_tick <= p && m[0];
            stage_tick <= p && m[1];
            timer_overflow <= p ? m[5:2] : 4'h0;
            #1 if (pin_out !== last) tog++;
            last = pin_out;
        end
    endtask
    task automatic t_regs();
        rd(8'h3d);
        chk(rd_val, 8'h00);
        rd(8'h3e);
        chk(rd_val, 8'h08);
        wr(8'h3e, 8'hfe);
        wr(8'h55, 8'hff);
        rd(8'h3e);
        chk(rd_val, 8'hfe);
        rd(8'h55);
        chk(rd_val, 8'h00);
        for (int f = 0; f < 4; f++) begin
            wr(8'h3d, 8'h04 | 8'(f));
            chk(8'(pll_feedback_mult), f == 1 ? 8'h1b : f == 2 ? 8'h1c : 8'h17);
            chk(8'(pll_power_down), 8'h01);
        end
    endtask
    task automatic t_levels();
        wr(8'h20, 8'h00);
        wr(8'h3d, 8'h20);
        chk(8'(pll_power_down), 8'h00);
        ticks(6'h03, 4);
        chk(8'(tog), 8'h00);
        chk(8'(pin_out), 8'h00);
        wr(8'h3d, 8'h30);
        ticks(6'h03, 4);
        chk(8'(tog), 8'h00);
        chk(8'(pin_out), 8'h01);
        chk(8'(pin_oe_n), 8'h00);
        for (int c = 12; c < 16; c++) begin
            wr(8'h3d, {4'(c), 4'h8});
            ticks(6'h3f, 8);
            chk(8'(tog), 8'h00);
            chk(8'(pin_out), 8'h00);
        end
    endtask
    task automatic t_clocks();
        for (int c = 4; c < 8; c++) begin
            wr(8'h3d, {4'(c), 4'h8});
            ticks(6'h01, 64);
            chk(8'(tog), 8'(64 >> (c - 4)));
        end
        wr(8'h3d, 8'h50);
        ticks(6'h01, 16);
        chk(8'(tog + pin_out), 8'h00);
        for (int t = 0; t < 4; t++) begin
            wr(8'h3d, {4'(8 + t), 4'h8});
            ticks(6'h04 << t, 3);
            chk(8'(tog), 8'h03);
            ticks(6'h3c & ~(6'h04 << t), 3);
            chk(8'(tog), 8'h00);
        end
        wr(8'h3e, 8'h08);
        wr(8'h3d, 8'h18);
        ticks(6'h02, 32);
        chk(8'(tog), 8'h04);
        wr(8'h3e, 8'h0a);
        ticks(6'h02, 40);
        chk(8'(tog), 8'h04);
        wr(8'h3d, 8'h1c);
        ticks(6'h02, 40);
        chk(8'(tog), 8'h00);
        wr(8'h3e, 8'h05);
        wr(8'h3d, 8'h18);
        ticks(6'h02, 40);
        chk(8'(tog), 8'h00);
    endtask
    // the pin is driven, then released to a level that differs from the last driven one
    task automatic t_gpio();
        wr(8'h3d, 8'h08);
        @(posedge mclk);
        gpio_drive <= 1'b1;
        gpio_out   <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk({pin_out, pin_oe_n}, 8'h02);
        @(posedge mclk);
        gpio_drive <= 1'b0;
        ext_level  <= 1'b0;
        repeat (8) @(posedge mclk);
        #1 chk({gpio_in_level, pin_oe_n}, 8'h01);
        @(posedge mclk);
        ext_level <= 1'b1;
        repeat (8) @(posedge mclk);
        #1 chk({gpio_in_level, pin_oe_n}, 8'h03);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        {reset, reg_write, reg_read, xtal_tick, stage_tick} = 5'h10;
        {gpio_out, gpio_drive, ext_level, reg_addr, reg_wdata, timer_overflow} = '0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_regs();
        t_levels();
        t_clocks();
        t_gpio();
        final_report();
    end
endmodule
bind pcoc_clock_output_ctrl pcoc_out_checker chk_i (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .timer_overflow(timer_overflow), .pll_power_down(pll_power_down),
    .pll_feedback_mult(pll_feedback_mult), .gpio_out(gpio_out), .gpio_drive(gpio_drive),
    .aux_clock_pin_out(aux_clock_pin_out), .aux_clock_pin_oe_n(aux_clock_pin_oe_n));
